/* hw/icdp_pkg.sv */
// Constants for the I2C count, address and data path.
// Assumes an APB slave with 32-bit data and byte addresses.
package icdp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CNT = 8'h00;
   localparam logic [7:0] OFS_RXD = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_TXD = 8'h0c;
   localparam logic [7:0] OFS_CTRL = 8'h10;
   localparam logic [7:0] OFS_STAT = 8'h14;
   // Control register fields
   localparam int CB_BC = 0;
   localparam int CB_FDF = 3;
   localparam int CB_RM = 7;
   localparam int CB_XA = 8;
   localparam int CB_TRX = 9;
   localparam int CB_MST = 10;
   localparam int CB_STP = 11;
   localparam int CB_STT = 13;
   localparam int CB_NACK = 15;
   // Status register fields
   localparam int SB_BUSY = 0;
   localparam int SB_TXFULL = 1;
   localparam int SB_RXFULL = 2;
   localparam int SB_NACKRX = 3;
   localparam int SB_GCALL = 4;
   // Reset values and fixed codes
   localparam logic [15:0] RST_CNT = 16'h0000;
   localparam logic [9:0] RST_ADDR = 10'h000;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [16:0] CNT_FULL = 17'h10000;
   localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
   localparam logic [2:0] ADDR_LAST = 3'h7;
   // Link engine states
   typedef enum logic [3:0] {
      L_IDLE, L_ADDR, L_AACK, L_FETCH, L_TX, L_TACK, L_RX, L_RACK, L_STOP
   } icdp_link_e;
endpackage : icdp_pkg

/* hw/icdp_sync.sv */
// Two flip-flop level synchroniser, one per bit.
// Assumes each bit is a level or a toggle, never a multi-bit word.
`timescale 1ns/1ns
module icdp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q; // First stage, read only by q

   // Two stages against metastability
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : icdp_sync

/* hw/icdp_top.sv */
// Count, address and data path of an I2C master with APB registers.
// Assumes link_clk is the free running bit clock; START/STOP drive is outside.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns
module icdp_top
   import icdp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic link_clk,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic start_cond,
   output logic stop_cond
);
   // Bus side registers
   logic [15:0] cnt_q; // Software-visible word count
   logic [9:0] addr_q; // Target address field
   logic [7:0] txd_q; // Transmit holding
   logic tx_full_q;
   logic [7:0] xd_q; // Word handed to the link
   logic txpend_q; // Link asked, nothing to give yet
   logic [7:0] rxd_q; // Receive holding
   logic rx_full_q;
   logic [2:0] bc_q;
   logic fdf_q, rm_q, xa_q, trx_q, mst_q, stp_q, nack_q;
   logic nackrx_q; // Sticky: NACK seen on the link
   logic go_q, txack_q; // Toggles towards the link
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [4:0] lprev_q; // Last seen link toggles
   logic [31:0] rdata_c;
   logic hit_c;
   // Link side registers
   icdp_link_e lst_q;
   logic lrst_m_q, lrst_q;
   logic ph_q, sa_q, nk_q;
   logic [2:0] bit_q;
   logic [7:0] sh_q; // Hidden shifter, both directions
   logic [7:0] lo_q; // Second address byte
   logic [7:0] rx_word_q;
   logic [16:0] cnt_l_q; // Internal down-counter
   logic [2:0] c_bc;
   logic c_rm, c_trx;
   logic oe_n_q, start_q, stop_q, busy_l_q;
   logic txreq_q, rxt_q, nsent_q, stopt_q, nrxt_q;
   logic go_seen_q, ack_seen_q;
   logic [5:0] ls_s; // Link state seen on clk
   logic [3:0] cs_s; // Bus state seen on link_clk
   logic [4:0] le;
   logic go_edge, ack_edge, stp_s, nack_s, busy_s;
   logic [2:0] bit_last;
   logic [7:0] addr_first;
   logic acc, wr, rd;

   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // Crossings, link to bus and bus to link
   icdp_sync #(.W(6)) u_sync_bus (
      .clk(clk),
      .rst(rst),
      .d({nrxt_q, stopt_q, nsent_q, rxt_q, txreq_q, busy_l_q}),
      .q(ls_s)
   );
   icdp_sync #(.W(4)) u_sync_link (
      .clk(link_clk),
      .rst(lrst_q),
      .d({nack_q, stp_q, txack_q, go_q}),
      .q(cs_s)
   );
   assign busy_s = ls_s[0];
   assign le = ls_s[5:1] ^ lprev_q;

   // Read mux; unused upper bits stay zero
   always_comb begin
      rdata_c = 32'h0;
      hit_c = 1'b1;
      case (paddr)
         OFS_CNT: rdata_c[15:0] = cnt_q;
         OFS_RXD: rdata_c[7:0] = rxd_q;
         OFS_ADDR: rdata_c[9:0] = addr_q;
         OFS_TXD: rdata_c[7:0] = txd_q;
         OFS_CTRL: begin
            rdata_c[CB_BC+:3] = bc_q;
            rdata_c[CB_FDF] = fdf_q;
            rdata_c[CB_RM] = rm_q;
            rdata_c[CB_XA] = xa_q;
            rdata_c[CB_TRX] = trx_q;
            rdata_c[CB_MST] = mst_q;
            rdata_c[CB_STP] = stp_q;
            rdata_c[CB_NACK] = nack_q;
         end
         OFS_STAT: begin
            rdata_c[SB_BUSY] = busy_s;
            rdata_c[SB_TXFULL] = tx_full_q;
            rdata_c[SB_RXFULL] = rx_full_q;
            rdata_c[SB_NACKRX] = nackrx_q;
            rdata_c[SB_GCALL] = (addr_q == RST_ADDR);
         end
         default: hit_c = 1'b0; // Unmapped
      endcase
   end

   // Read data and error captured in the setup cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (psel & ~penable) begin
         prdata_q <= pwrite ? 32'h0 : rdata_c;
         pslverr_q <= ~hit_c;
      end
   end

   // Count and address registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= RST_CNT;
         addr_q <= RST_ADDR;
      end else if (wr && paddr == OFS_CNT) begin
         cnt_q <= pwdata[15:0];
      end else if (wr && paddr == OFS_ADDR) begin
         addr_q <= pwdata[9:0];
      end
   end

   // Control bits; the link clears stop and nack, a write wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {bc_q, fdf_q, rm_q, xa_q, trx_q, mst_q} <= 8'h00;
         stp_q <= 1'b0;
         nack_q <= 1'b0;
         go_q <= 1'b0;
      end else if (wr && paddr == OFS_CTRL) begin
         bc_q <= pwdata[CB_BC+:3];
         fdf_q <= pwdata[CB_FDF];
         rm_q <= pwdata[CB_RM];
         xa_q <= pwdata[CB_XA];
         trx_q <= pwdata[CB_TRX];
         mst_q <= pwdata[CB_MST];
         stp_q <= pwdata[CB_STP];
         nack_q <= pwdata[CB_NACK];
         // Start only when idle and master
         if (pwdata[CB_STT] & pwdata[CB_MST] & ~busy_s) begin
            go_q <= ~go_q;
         end
      end else begin
         if (le[3]) begin
            stp_q <= 1'b0;
         end
         if (le[2]) begin
            nack_q <= 1'b0;
         end
      end
   end

   // Transmit holding and hand-over to the link
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txd_q <= RST_DATA;
         tx_full_q <= 1'b0;
         xd_q <= RST_DATA;
         txpend_q <= 1'b0;
         txack_q <= 1'b0;
      end else begin
         if ((txpend_q | le[0]) & tx_full_q) begin
            xd_q <= txd_q;
            txack_q <= ~txack_q;
            txpend_q <= 1'b0;
         end else if (le[0]) begin
            txpend_q <= 1'b1;
         end
         if (wr && paddr == OFS_TXD) begin
            txd_q <= pwdata[7:0];
            tx_full_q <= 1'b1;
         end else if ((txpend_q | le[0]) & tx_full_q) begin
            tx_full_q <= 1'b0;
         end
      end
   end

   // Receive holding and sticky NACK flag; a set beats a clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxd_q <= RST_DATA;
         rx_full_q <= 1'b0;
         nackrx_q <= 1'b0;
         lprev_q <= 5'h00;
      end else begin
         lprev_q <= ls_s[5:1];
         if (le[1]) begin
            rxd_q <= rx_word_q;
            rx_full_q <= 1'b1;
         end else if (rd && paddr == OFS_RXD) begin
            rx_full_q <= 1'b0;
         end
         if (le[4]) begin
            nackrx_q <= 1'b1;
         end else if (wr && paddr == OFS_STAT && pwdata[SB_NACKRX]) begin
            nackrx_q <= 1'b0;
         end
      end
   end

   // Link reset, released on link_clk
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         lrst_m_q <= 1'b1;
         lrst_q <= 1'b1;
      end else begin
         lrst_m_q <= 1'b0;
         lrst_q <= lrst_m_q;
      end
   end

   assign go_edge = cs_s[0] ^ go_seen_q;
   assign ack_edge = cs_s[1] ^ ack_seen_q;
   assign stp_s = cs_s[2];
   assign nack_s = cs_s[3];
   assign bit_last = c_bc - 3'h1;
   // Ten-bit first byte carries a write; zero address is a general call
   assign addr_first = xa_q ? {TEN_BIT_PREFIX, addr_q[9:8], 1'b0}
                            : {addr_q[6:0], ~trx_q & (addr_q != RST_ADDR)};

   // Internal down-counter, loaded at every start
   always_ff @(posedge link_clk or posedge lrst_q) begin
      if (lrst_q) begin
         cnt_l_q <= CNT_FULL;
      end else if (lst_q == L_IDLE && go_edge && mst_q) begin
         cnt_l_q <= (cnt_q == RST_CNT) ? CNT_FULL : {1'b0, cnt_q};
      end else if (!c_rm && ((lst_q == L_TACK && ph_q) || (lst_q == L_RACK && !ph_q))) begin
         cnt_l_q <= cnt_l_q - 17'h1;
      end
   end

   // Busy level for software
   always_ff @(posedge link_clk or posedge lrst_q) begin
      if (lrst_q) begin
         busy_l_q <= 1'b0;
      end else begin
         busy_l_q <= (lst_q != L_IDLE);
      end
   end

   // Link engine: address, words, acknowledge slots
   always_ff @(posedge link_clk or posedge lrst_q) begin
      if (lrst_q) begin
         lst_q <= L_IDLE;
         {ph_q, sa_q, nk_q, c_rm, c_trx} <= 5'h00;
         {bit_q, c_bc} <= 6'h00;
         {sh_q, lo_q, rx_word_q} <= 24'h0;
         {oe_n_q, start_q, stop_q} <= 3'b100;
         {txreq_q, rxt_q, nsent_q, stopt_q, nrxt_q} <= 5'h00;
         go_seen_q <= 1'b0;
         ack_seen_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         stop_q <= 1'b0;
         case (lst_q)
            L_IDLE: begin
               oe_n_q <= 1'b1;
               bit_q <= 3'h0;
               ph_q <= 1'b0;
               if (go_edge) begin
                  go_seen_q <= cs_s[0];
                  if (mst_q) begin
                     c_rm <= rm_q;
                     c_trx <= trx_q;
                     c_bc <= bc_q;
                     lo_q <= addr_q[7:0];
                     start_q <= 1'b1;
                     sh_q <= addr_first;
                     sa_q <= xa_q;
                     if (!fdf_q) begin
                        lst_q <= L_ADDR;
                     end else if (trx_q) begin
                        txreq_q <= ~txreq_q;
                        lst_q <= L_FETCH;
                     end else begin
                        sh_q <= 8'h00;
                        lst_q <= L_RX;
                     end
                  end
               end
            end
            L_ADDR, L_TX: begin
               oe_n_q <= sh_q[7]; // Release for a one
               sh_q <= {sh_q[6:0], 1'b0};
               bit_q <= bit_q + 3'h1;
               if (lst_q == L_ADDR && bit_q == ADDR_LAST) begin
                  lst_q <= L_AACK;
                  bit_q <= 3'h0;
               end else if (lst_q == L_TX && bit_q == bit_last) begin
                  lst_q <= L_TACK;
                  bit_q <= 3'h0;
               end
            end
            L_AACK: begin
               oe_n_q <= 1'b1;
               ph_q <= ~ph_q;
               if (ph_q) begin
                  if (sda_in) begin
                     nrxt_q <= ~nrxt_q;
                     lst_q <= L_STOP;
                  end else if (sa_q) begin
                     sa_q <= 1'b0;
                     sh_q <= lo_q;
                     lst_q <= L_ADDR;
                  end else if (c_trx) begin
                     txreq_q <= ~txreq_q;
                     lst_q <= L_FETCH;
                  end else begin
                     sh_q <= 8'h00;
                     lst_q <= L_RX;
                  end
               end
            end
            L_FETCH: begin
               if (ack_edge) begin
                  ack_seen_q <= cs_s[1];
                  sh_q <= xd_q << (3'h0 - c_bc);
                  lst_q <= L_TX;
               end else if (c_rm && stp_s) begin
                  // Repeat mode: a stop request while no word is waiting ends the frame
                  lst_q <= L_STOP;
               end
            end
            L_TACK: begin
               oe_n_q <= 1'b1;
               ph_q <= ~ph_q;
               if (ph_q) begin
                  if (sda_in) begin
                     nrxt_q <= ~nrxt_q;
                     lst_q <= L_STOP;
                  end else if (c_rm ? stp_s : (cnt_l_q == 17'h1)) begin
                     lst_q <= stp_s ? L_STOP : L_IDLE;
                  end else begin
                     txreq_q <= ~txreq_q;
                     lst_q <= L_FETCH;
                  end
               end
            end
            L_RX: begin
               sh_q <= {sh_q[6:0], sda_in};
               bit_q <= bit_q + 3'h1;
               if (bit_q == bit_last) begin
                  lst_q <= L_RACK;
                  bit_q <= 3'h0;
               end
            end
            L_RACK: begin
               ph_q <= ~ph_q;
               if (!ph_q) begin
                  rx_word_q <= sh_q;
                  rxt_q <= ~rxt_q;
                  nk_q <= nack_s | (!c_rm && cnt_l_q == 17'h1);
                  // Released line is a NACK, pulled low is an ACK
                  oe_n_q <= nack_s | (!c_rm && cnt_l_q == 17'h1);
                  if (nack_s) begin
                     nsent_q <= ~nsent_q;
                  end
               end else begin
                  oe_n_q <= 1'b1;
                  sh_q <= 8'h00;
                  if (nk_q) begin
                     lst_q <= stp_s ? L_STOP : L_IDLE;
                  end else if (c_rm && stp_s) begin
                     lst_q <= L_STOP;
                  end else begin
                     lst_q <= L_RX;
                  end
               end
            end
            L_STOP: begin
               oe_n_q <= 1'b1;
               stop_q <= 1'b1;
               stopt_q <= ~stopt_q;
               lst_q <= L_IDLE;
            end
            default: lst_q <= L_IDLE;
         endcase
      end
   end

   // Open-drain pin: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_n = oe_n_q;
   assign start_cond = start_q;
   assign stop_cond = stop_q;

   // Checks on the link side
   sequence l_start_s;
      (lst_q == L_IDLE) && go_edge && mst_q;
   endsequence
   sequence l_tword_s;
      (lst_q == L_TACK) && ph_q && !sda_in;
   endsequence

   cnt_load_a: assert property (@(posedge link_clk) disable iff (lrst_q)
      l_start_s |=> cnt_l_q == (($past(cnt_q) == 16'h0) ? CNT_FULL : {1'b0, $past(cnt_q)}))
      else $error("counter load wrong");
   cnt_dec_a: assert property (@(posedge link_clk) disable iff (lrst_q)
      (l_tword_s and ##0 !c_rm) |=> cnt_l_q == $past(cnt_l_q) - 17'h1)
      else $error("counter did not drop by one");
   rm_ignore_a: assert property (@(posedge link_clk) disable iff (lrst_q)
      (lst_q != L_IDLE && c_rm) |=> $stable(cnt_l_q))
      else $error("counter moved in repeat mode");
   stop_end_a: assert property (@(posedge link_clk) disable iff (lrst_q)
      (l_tword_s and ##0 (!c_rm && cnt_l_q == 17'h1 && stp_s)) |=> lst_q == L_STOP ##1 stop_q)
      else $error("no STOP at count end");
   addr_7bit_a: assert property (@(posedge link_clk) disable iff (lrst_q)
      (l_start_s and ##0 (!fdf_q && !xa_q)) |=> sh_q[7:1] == $past(addr_q[6:0]))
      else $error("seven-bit address wrong");
   free_fmt_a: assert property (@(posedge link_clk) disable iff (lrst_q)
      l_start_s |=> (lst_q == L_ADDR) == !$past(fdf_q))
      else $error("address phase choice wrong");
   rx_nack_a: assert property (@(posedge link_clk) disable iff (lrst_q)
      (lst_q == L_RACK && !ph_q && !c_rm) |=> oe_n_q == ($past(cnt_l_q) == 17'h1 || $past(nack_s)))
      else $error("receiver ack wrong");
   tx_load_a: assert property (@(posedge link_clk) disable iff (lrst_q)
      (lst_q == L_FETCH && ack_edge && c_bc == 3'h0) |=> sh_q == $past(xd_q))
      else $error("transmit shifter not loaded");

   // Checks on the bus side
   cnt_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(wr && paddr == OFS_CNT) |=> $stable(cnt_q))
      else $error("visible count changed");
   rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
      (psel && !penable && !pwrite && paddr == OFS_CNT) |=> prdata[31:16] == 16'h0)
      else $error("reserved bits not zero");
   rx_copy_a: assert property (@(posedge clk) disable iff (rst)
      le[1] |=> rxd_q == $past(rx_word_q) && rx_full_q)
      else $error("receive holding not updated");
endmodule : icdp_top

/* verif/icdp_slave_model.sv */
// Far-end I2C slave: acks the first byte and written words, serves a fixed read level.
// Assumes the bench forms the data line as the AND of both open-drain enables.
`timescale 1ns/1ns
module icdp_slave_model (
   input wire logic link_clk,
   input wire logic rst,
   input wire logic sda_oe_n,
   input wire logic start_cond,
   input wire logic stop_cond,
   input wire logic rd_level,
   output logic slv_oe_n,
   output logic [7:0] first_byte,
   output logic [15:0] low_cnt,
   output logic [7:0] stop_cnt
);
   logic [4:0] pos_q; // Link cycles since START, saturating
   // Frame position, first byte seen, cycles pulled low by the device
   always_ff @(posedge link_clk or posedge rst) begin
      if (rst) begin
         pos_q <= 5'h00;
         first_byte <= 8'h00;
         low_cnt <= 16'h0000;
         stop_cnt <= 8'h00;
      end else if (start_cond) begin
         pos_q <= 5'h01;
         low_cnt <= 16'h0000;
      end else begin
         if (pos_q != 5'h00 && pos_q != 5'h1f) pos_q <= pos_q + 5'h01;
         if (pos_q >= 5'h01 && pos_q <= 5'h08) first_byte <= {first_byte[6:0], sda_oe_n};
         if (!sda_oe_n) low_cnt <= low_cnt + 16'h0001;
         // STOP ends the frame and releases the line
         if (stop_cond) begin
            pos_q <= 5'h00;
            stop_cnt <= stop_cnt + 8'h01;
         end
      end
   end
   // Ack slot after the first byte, then ack writes or drive the read level
   always_comb begin
      if (pos_q == 5'h09) slv_oe_n = 1'b0;
      else if (pos_q > 5'h09) slv_oe_n = first_byte[0] ? rd_level : 1'b0;
      else slv_oe_n = 1'b1;
   end
endmodule : icdp_slave_model

/* verif/i2c_count_address_data_path_tb.sv */
// Bench: APB master, far-end slave model, random and corner transfers.
// Assumes the register map and control layout of the package.
`timescale 1ns/1ns
module i2c_count_address_data_path_tb
   import icdp_pkg::*;
;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic sda_in;
   logic sda_oe_n;
   logic start_cond;
   logic stop_cond;
   logic slv_oe_n;
   logic rd_level = 1'b1;
   logic [7:0] first_byte;
   logic [15:0] low_cnt;
   logic [7:0] stop_cnt;
   logic [7:0] wq [0:3]; // Words of the next transfer
   logic [31:0] rv; // Last read data
   logic ev; // Last error response
   int num_errors = 0;
   int tests_run = 0;
   int seed = 94;
   int nst = 0; // Expected STOP count
   // Bus clock and a link clock of unrelated phase
   always #20 clk = ~clk;
   always begin
      if ($time == 0) #5;
      #6 link_clk = ~link_clk;
   end
   // Open-drain line: either end pulls it low
   assign sda_in = sda_oe_n & slv_oe_n;
   icdp_top dut_u (.clk(clk), .rst(rst), .link_clk(link_clk), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sda_in(sda_in), .sda_out(), .sda_oe_n(sda_oe_n),
      .start_cond(start_cond), .stop_cond(stop_cond));
   icdp_slave_model slv_u (.link_clk(link_clk), .rst(rst), .sda_oe_n(sda_oe_n),
      .start_cond(start_cond), .stop_cond(stop_cond), .rd_level(rd_level),
      .slv_oe_n(slv_oe_n), .first_byte(first_byte), .low_cnt(low_cnt), .stop_cnt(stop_cnt));
   // Verdict and end of run
   task automatic results();
      $display("Compared %0d, mismatched %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results
   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         num_errors++;
         results();
      end
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Zero bits among the low nb bits of a word
   function automatic int zb(input logic [7:0] v, input int nb);
      int z;
      z = 0;
      for (int k = 0; k < nb; k++) if (!v[k]) z++;
      return z;
   endfunction : zb
   // Fill right-aligned random words; returns their zero bits
   task automatic fill(input int nw, input int nb, output int z);
      z = 0;
      for (int k = 0; k < nw; k++) begin
         wq[k] = 8'($random(seed)) >> (8 - nb);
         z += zb(wq[k], nb);
      end
   endtask : fill
   // Run a transfer, feed words, wait for idle, check the wire
   task automatic xfer(input logic [15:0] ctl, input logic [9:0] a, input logic [15:0] cnt,
         input int nw, input logic [7:0] fb, input int el, input int sd);
      int fed;
      int n;
      int idle;
      logic stop_request;
      fed = 0;
      idle = 0;
      stop_request = 1'b0;
      apb(1'b1, OFS_ADDR, {22'h0, a});
      if (cnt != 16'h0) apb(1'b1, OFS_CNT, {16'h0, cnt});
      apb(1'b1, OFS_CTRL, {16'h0, ctl | 16'h2400});
      for (n = 0; n < 3000 && idle < 2; n++) begin
         apb(1'b0, OFS_STAT, 32'h0);
         idle = (rv[SB_BUSY] || n < 4) ? 0 : idle + 1;
         if (!rv[SB_TXFULL] && fed < nw) begin
            apb(1'b1, OFS_TXD, {24'h0, wq[fed]});
            fed++;
         end else if (ctl[CB_RM] && fed == nw && !rv[SB_TXFULL] && !stop_request) begin
            apb(1'b1, OFS_CTRL, {16'h0, ctl | 16'h0c00});
            stop_request = 1'b1;
         end
      end
      if (idle < 2) begin
         num_errors++;
         results();
      end
      nst += sd;
      chk({24'h0, first_byte}, {24'h0, fb});
      chk({16'h0, low_cnt}, 32'(el));
      chk({24'h0, stop_cnt}, 32'(nst));
      $display("Transfer done, control %h", ctl);
   endtask : xfer
   // Main sequence
   initial begin
      logic [9:0] a;
      logic [2:0] bc;
      logic [7:0] fb;
      logic [15:0] c;
      int nb;
      int z;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b0, OFS_CNT, 32'h0);
      chk(rv, {16'h0, RST_CNT});
      apb(1'b0, OFS_ADDR, 32'h0);
      chk(rv, {22'h0, RST_ADDR});
      // Seven-bit writes: general call, ignored upper bits, random
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 10'h000 : (i == 1) ? 10'h380 : 10'($random(seed));
         bc = 3'($random(seed));
         nb = (bc == 3'h0) ? 8 : int'(bc);
         c = 16'(1 + i % 3);
         fb = {a[6:0], 1'b0};
         fill(int'(c), nb, z);
         xfer(16'h0a00 | {13'h0, bc}, a, c, int'(c), fb, z + zb(fb, 8), 1);
         apb(1'b0, OFS_STAT, 32'h0);
         chk({31'h0, rv[SB_GCALL]}, {31'h0, a == 10'h000});
         apb(1'b0, OFS_CNT, 32'h0);
         chk(rv, {16'h0, c});
      end
      // Ten-bit address: both address bytes on the wire
      a = 10'($random(seed));
      fb = {5'h1e, a[9:8], 1'b0};
      fill(1, 8, z);
      xfer(16'h0b00, a, 16'h1, 1, fb, z + zb(fb, 8) + zb(a[7:0], 8), 1);
      // Free format: no address, line stays released while the word is fetched
      wq[0] = 8'($random(seed)) & 8'hfe;
      xfer(16'h0a08, a, 16'h1, 1, 8'hff, zb(wq[0], 8), 1);
      // Repeat mode: count ignored, three words, STOP on request
      a = 10'($random(seed));
      fill(3, 8, z);
      xfer(16'h0280, a, 16'h1, 3, {a[6:0], 1'b0}, z + zb({a[6:0], 1'b0}, 8), 1);
      // No STOP request; second run reloads the kept count
      for (int i = 0; i < 2; i++) begin
         fill(2, 8, z);
         c = (i == 0) ? 16'h2 : 16'h0;
         xfer(16'h0200, a, c, 2, {a[6:0], 1'b0}, z + zb({a[6:0], 1'b0}, 8), 0);
      end
      // Receive: acks until the last word, right-aligned data
      a = {9'($random(seed)), 1'b1};
      fb = {a[6:0], 1'b1};
      rd_level <= 1'b1;
      xfer(16'h0803, a, 16'h2, 0, fb, zb(fb, 8) + 1, 1);
      apb(1'b0, OFS_RXD, 32'h0);
      chk(rv, 32'h07);
      rd_level <= 1'b0;
      xfer(16'h0800, a, 16'h1, 0, fb, zb(fb, 8), 1);
      // Forced NACK on the first word; force and stop bits clear themselves
      xfer(16'h8800, a, 16'h2, 0, fb, zb(fb, 8), 1);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rv, 32'h0000_0400);
      apb(1'b0, OFS_RXD, 32'h0);
      chk(rv, 32'h00);
      apb(1'b1, OFS_RXD, 32'hffff_ffff);
      apb(1'b0, OFS_RXD, 32'h0);
      chk(rv, 32'h00);
      // Upper bits read zero and ignore writes
      apb(1'b1, OFS_CNT, 32'hffff_ffff);
      apb(1'b0, OFS_CNT, 32'h0);
      chk(rv, 32'h0000_ffff);
      apb(1'b1, OFS_ADDR, 32'hffff_ffff);
      apb(1'b0, OFS_ADDR, 32'h0);
      chk(rv, 32'h0000_03ff);
      apb(1'b1, OFS_TXD, 32'hffff_ffff);
      apb(1'b0, OFS_TXD, 32'h0);
      chk(rv, 32'h0000_00ff);
      // Unmapped place answers with an error and zero data
      apb(1'b0, 8'h40, 32'h0);
      chk({rv[31:1], ev}, 32'h1);
      results();
   end
endmodule : i2c_count_address_data_path_tb
